// >>> hdl/twsc_pkg.sv
package twsc_pkg;
  // Bus clock and serial clock quarter period
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned SCL_QTR_NS = 2500;
  localparam logic [7:0] QTR_CYC = 8'(SCL_QTR_NS / CLK_NS);
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTL = 6'h28;
  localparam logic [5:0] IDX_DATA = 6'h29;
  localparam logic [5:0] IDX_ROUTE = 6'h2a;
  // Status/control field positions
  localparam int B_ROLE = 7;
  localparam int B_PROCEED = 6;
  localparam int B_XMIT = 5;
  localparam int B_ACK = 4;
  localparam int B_ADDR = 3;
  localparam int B_LOST = 2;
  localparam int B_RSTOP = 1;
  localparam int B_ON = 0;
  // Routing field positions
  localparam int B_POS = 7;
  localparam int B_WIDTH = 1;
  localparam logic RST_BIT = 1'b0;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_START = 9'h002,
    S_BIT = 9'h004,
    S_ACK = 9'h008,
    S_WAIT = 9'h010,
    S_STOP = 9'h020,
    S_TBIT = 9'h040,
    S_TACK = 9'h080,
    S_TWAIT = 9'h100
  } twsc_state_t;
endpackage : twsc_pkg

// >>> hdl/twsc_sync.sv
`timescale 1ns/100ps
module twsc_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] d,
  output logic [3:0] q
);
  logic [3:0] meta;
  // Idle bus reads high, so reset to ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 4'hf;
      q <= 4'hf;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : twsc_sync

// >>> hdl/twsc_ctrl.sv
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
// Operation
// - Position and width bits of routing register choose port 1 or port 2.
// - Both routing bits clear to zero on reset.
// - Pull-ups on the two selected pins are off while serial function owns them.
// - Hardware acts as controller, target, and in multi-controller buses.
// - Bus is stalled with clock held low while firmware services an event.
// - Interrupt after every transmitted or received byte.
// - Interrupt on stop condition seen as receiving target with ack bit set.
// - Interrupt when bus arbitration is lost.
// - Data location has separate transmit and receive byte stores.
// - Status bits are settled when the byte interrupt is raised.
// - Clock on bit 0, data on bit 1 of the selected port.
// - Enable bit forces the two low pins of the port to open drain.
// - Open drain pin drives low for 0, releases for 1.
// - Only the selected port is driven while the function is on; the other port is released.
// - Data register holds one byte and is undefined after reset.
// - Setting role issues start and first byte; clearing it issues stop.
// - Proceed bit launches next byte, reads 1 while busy.
// - Receiving, ack bit pulls data low; transmitting, it reads far-end ack.
// - Lost arbitration clears role, sets lost flag and interrupts.
module twsc_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [1:0] p1_i,
  output logic [1:0] p1_o,
  output logic [1:0] p1_oe,
  output logic p1_pullup_en,
  input wire logic [1:0] p2_i,
  output logic [1:0] p2_o,
  output logic [1:0] p2_oe,
  output logic p2_pullup_en,
  output logic irq
);
  twsc_pkg::twsc_state_t st;
  logic reg_we;
  logic [5:0] reg_widx;
  logic [7:0] wb;
  logic [5:0] reg_ridx;
  logic [7:0] rbyte;
  logic [3:0] pins;
  logic controller_role;
  logic proceed_inflight;
  logic transmit_mode;
  logic ack_bit;
  logic addr_phase;
  logic contention_lost_or_repeat;
  logic rx_stop;
  logic serial_function_on;
  logic route_pos;
  logic route_width;
  logic [7:0] tx_data;
  logic [7:0] rx_data;
  logic [7:0] shreg;
  logic [7:0] ctl_byte;
  logic [7:0] route_byte;
  logic [7:0] qcnt;
  logic [2:0] bitn;
  logic [1:0] ph;
  logic tdone;
  logic byte_tx;
  logic scl_lo;
  logic sda_lo;
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  logic use_p2;
  logic ctl_wr;
  logic ctl_st;
  logic tgt_st;
  logic stretch;
  logic tick;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;

  twsc_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .reg_we(reg_we),
    .reg_widx(reg_widx),
    .reg_wbyte(wb),
    .reg_ridx(reg_ridx),
    .reg_rbyte(rbyte)
  );

  twsc_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({p2_i, p1_i}),
    .q(pins)
  );

  assign use_p2 = route_width | route_pos;
  assign scl_s = use_p2 ? pins[2] : pins[0];
  assign sda_s = use_p2 ? pins[3] : pins[1];
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  // Status writes are locked out while a byte is in flight
  assign ctl_wr = reg_we && (reg_widx == twsc_pkg::IDX_CTL) && !proceed_inflight;
  assign ctl_st = (st == twsc_pkg::S_START) || (st == twsc_pkg::S_BIT) ||
                  (st == twsc_pkg::S_ACK) || (st == twsc_pkg::S_STOP);
  assign tgt_st = (st == twsc_pkg::S_TBIT) || (st == twsc_pkg::S_TACK) ||
                  (st == twsc_pkg::S_TWAIT);
  // Another controller holding clock low stretches our phase
  assign stretch = !scl_lo && !scl_s;
  assign tick = (qcnt == twsc_pkg::QTR_CYC - 8'h01) && !stretch;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !ctl_st || tick) begin
      qcnt <= 8'h00;
    end else if (!stretch) begin
      qcnt <= qcnt + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_pos <= twsc_pkg::RST_BIT;
      route_width <= twsc_pkg::RST_BIT;
    end else if (reg_we && reg_widx == twsc_pkg::IDX_ROUTE) begin
      route_pos <= wb[twsc_pkg::B_POS];
      route_width <= wb[twsc_pkg::B_WIDTH];
    end
  end

  // Transmit byte has no reset value
  always_ff @(posedge aclk) begin
    if (reg_we && reg_widx == twsc_pkg::IDX_DATA) begin
      tx_data <= wb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= twsc_pkg::S_IDLE;
      controller_role <= 1'b0;
      proceed_inflight <= 1'b0;
      transmit_mode <= 1'b0;
      ack_bit <= 1'b0;
      addr_phase <= 1'b0;
      contention_lost_or_repeat <= 1'b0;
      rx_stop <= 1'b0;
      serial_function_on <= 1'b0;
      ph <= 2'h0;
      bitn <= 3'h0;
      tdone <= 1'b0;
      byte_tx <= 1'b0;
      scl_lo <= 1'b0;
      sda_lo <= 1'b0;
      shreg <= 8'h00;
      irq <= 1'b0;
    end else begin
      irq <= 1'b0;
      if (ctl_wr) begin
        controller_role <= wb[twsc_pkg::B_ROLE];
        transmit_mode <= wb[twsc_pkg::B_XMIT];
        ack_bit <= wb[twsc_pkg::B_ACK];
        contention_lost_or_repeat <= wb[twsc_pkg::B_LOST];
        serial_function_on <= wb[twsc_pkg::B_ON];
        if (wb[twsc_pkg::B_PROCEED]) begin
          proceed_inflight <= 1'b1;
          addr_phase <= 1'b0;
          rx_stop <= 1'b0;
        end
      end
      // Hardware updates below come later, so they beat a firmware write in the same cycle
      if (ctl_st && tick) begin
        ph <= ph + 2'h1;
      end
      case (st)
        twsc_pkg::S_IDLE: begin
          if (serial_function_on && controller_role) begin
            st <= twsc_pkg::S_START;
            proceed_inflight <= 1'b1;
            ph <= 2'h0;
          end else if (serial_function_on && start_det) begin
            st <= twsc_pkg::S_TBIT;
            addr_phase <= 1'b1;
            proceed_inflight <= 1'b1;
            byte_tx <= 1'b0;
            bitn <= 3'h7;
            tdone <= 1'b0;
          end
        end
        twsc_pkg::S_START: begin
          if (tick) begin
            case (ph)
              2'h0: scl_lo <= 1'b0;
              2'h1: sda_lo <= 1'b1;
              2'h2: scl_lo <= 1'b1;
              default: begin
                // Restart flag drops here so it cannot read as lost
                contention_lost_or_repeat <= 1'b0;
                st <= twsc_pkg::S_BIT;
                shreg <= tx_data;
                byte_tx <= 1'b1;
                bitn <= 3'h7;
              end
            endcase
          end
        end
        twsc_pkg::S_BIT: begin
          if (tick) begin
            case (ph)
              2'h0: sda_lo <= byte_tx ? ~shreg[7] : 1'b0;
              2'h1: scl_lo <= 1'b0;
              2'h2: begin
                shreg <= {shreg[6:0], sda_s};
                if (byte_tx && shreg[7] && !sda_s) begin
                  controller_role <= 1'b0;
                  contention_lost_or_repeat <= 1'b1;
                  addr_phase <= 1'b1;
                  st <= twsc_pkg::S_TBIT;
                  byte_tx <= 1'b0;
                  sda_lo <= 1'b0;
                  tdone <= (bitn == 3'h0);
                  bitn <= bitn - 3'h1;
                end
              end
              default: begin
                scl_lo <= 1'b1;
                bitn <= bitn - 3'h1;
                if (bitn == 3'h0) begin
                  st <= twsc_pkg::S_ACK;
                end
              end
            endcase
          end
        end
        twsc_pkg::S_ACK: begin
          if (tick) begin
            case (ph)
              2'h0: sda_lo <= byte_tx ? 1'b0 : ack_bit;
              2'h1: scl_lo <= 1'b0;
              2'h2: begin
                if (byte_tx) begin
                  ack_bit <= ~sda_s;
                end
              end
              default: begin
                scl_lo <= 1'b1;
                if (!byte_tx) begin
                  rx_data <= shreg;
                end
                st <= twsc_pkg::S_WAIT;
                proceed_inflight <= 1'b0;
                irq <= 1'b1;
              end
            endcase
          end
        end
        twsc_pkg::S_WAIT: begin
          // Clock stays low until firmware answers
          if (!controller_role) begin
            st <= twsc_pkg::S_STOP;
            proceed_inflight <= 1'b1;
            sda_lo <= 1'b1;
            ph <= 2'h0;
          end else if (proceed_inflight && contention_lost_or_repeat) begin
            st <= twsc_pkg::S_START;
            sda_lo <= 1'b0;
            ph <= 2'h0;
          end else if (proceed_inflight) begin
            st <= twsc_pkg::S_BIT;
            shreg <= tx_data;
            byte_tx <= transmit_mode;
            bitn <= 3'h7;
            ph <= 2'h0;
          end
        end
        twsc_pkg::S_STOP: begin
          if (tick) begin
            case (ph)
              2'h0: sda_lo <= 1'b1;
              2'h1: scl_lo <= 1'b0;
              2'h2: sda_lo <= 1'b0;
              default: begin
                st <= twsc_pkg::S_IDLE;
                proceed_inflight <= 1'b0;
              end
            endcase
          end
        end
        twsc_pkg::S_TBIT: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            tdone <= (bitn == 3'h0);
            bitn <= bitn - 3'h1;
          end else if (scl_fall && tdone) begin
            st <= twsc_pkg::S_TWAIT;
            scl_lo <= 1'b1;
            sda_lo <= 1'b0;
            if (!byte_tx) begin
              rx_data <= shreg;
            end
            proceed_inflight <= 1'b0;
            irq <= 1'b1;
          end else if (scl_fall && byte_tx) begin
            sda_lo <= ~shreg[7];
          end
        end
        twsc_pkg::S_TWAIT: begin
          if (proceed_inflight) begin
            st <= twsc_pkg::S_TACK;
            scl_lo <= 1'b0;
            sda_lo <= byte_tx ? 1'b0 : ack_bit;
          end
        end
        twsc_pkg::S_TACK: begin
          if (scl_rise && byte_tx) begin
            ack_bit <= ~sda_s;
          end else if (scl_fall) begin
            st <= twsc_pkg::S_TBIT;
            byte_tx <= transmit_mode;
            shreg <= tx_data;
            bitn <= 3'h7;
            tdone <= 1'b0;
            sda_lo <= transmit_mode ? ~tx_data[7] : 1'b0;
          end
        end
        default: st <= twsc_pkg::S_IDLE;
      endcase
      if (tgt_st && stop_det) begin
        st <= twsc_pkg::S_IDLE;
        proceed_inflight <= 1'b0;
        scl_lo <= 1'b0;
        sda_lo <= 1'b0;
        if (!byte_tx && ack_bit) begin
          rx_stop <= 1'b1;
          irq <= 1'b1;
        end
      end else if (tgt_st && start_det) begin
        st <= twsc_pkg::S_TBIT;
        addr_phase <= 1'b1;
        proceed_inflight <= 1'b1;
        byte_tx <= 1'b0;
        bitn <= 3'h7;
        tdone <= 1'b0;
        scl_lo <= 1'b0;
        sda_lo <= 1'b0;
      end
      if (!serial_function_on) begin
        st <= twsc_pkg::S_IDLE;
        scl_lo <= 1'b0;
        sda_lo <= 1'b0;
      end
    end
  end

  // Pins only ever pull low; a one is a release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p1_o <= 2'b00;
      p2_o <= 2'b00;
      p1_oe <= 2'b00;
      p2_oe <= 2'b00;
      p1_pullup_en <= 1'b1;
      p2_pullup_en <= 1'b1;
    end else begin
      p1_o <= 2'b00;
      p2_o <= 2'b00;
      p1_oe <= (serial_function_on && !use_p2) ? {sda_lo, scl_lo} : 2'b00;
      p2_oe <= (serial_function_on && use_p2) ? {sda_lo, scl_lo} : 2'b00;
      p1_pullup_en <= !(serial_function_on && !use_p2);
      p2_pullup_en <= !(serial_function_on && use_p2);
    end
  end

  always_comb begin
    ctl_byte = 8'h00;
    ctl_byte[twsc_pkg::B_ROLE] = controller_role;
    ctl_byte[twsc_pkg::B_PROCEED] = proceed_inflight;
    ctl_byte[twsc_pkg::B_XMIT] = transmit_mode;
    ctl_byte[twsc_pkg::B_ACK] = ack_bit;
    ctl_byte[twsc_pkg::B_ADDR] = addr_phase;
    ctl_byte[twsc_pkg::B_LOST] = contention_lost_or_repeat;
    ctl_byte[twsc_pkg::B_RSTOP] = rx_stop;
    ctl_byte[twsc_pkg::B_ON] = serial_function_on;
    route_byte = 8'h00;
    route_byte[twsc_pkg::B_POS] = route_pos;
    route_byte[twsc_pkg::B_WIDTH] = route_width;
  end

  always_comb begin
    case (reg_ridx)
      twsc_pkg::IDX_CTL: rbyte = ctl_byte;
      twsc_pkg::IDX_DATA: rbyte = rx_data;
      twsc_pkg::IDX_ROUTE: rbyte = route_byte;
      default: rbyte = 8'h00;
    endcase
  end
endmodule : twsc_ctrl

// >>> hdl/twsc_axil.sv
`timescale 1ns/100ps
module twsc_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic reg_we,
  output logic [5:0] reg_widx,
  output logic [7:0] reg_wbyte,
  output logic [5:0] reg_ridx,
  input wire logic [7:0] reg_rbyte
);
  logic [5:0] aw_idx;
  logic w_lane;

  function automatic logic hit(input logic [5:0] i);
    hit = (i == twsc_pkg::IDX_CTL) || (i == twsc_pkg::IDX_DATA) ||
          (i == twsc_pkg::IDX_ROUTE);
  endfunction : hit

  assign reg_ridx = araddr[7:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= twsc_pkg::RESP_OK;
      reg_we <= 1'b0;
      reg_widx <= 6'h00;
      reg_wbyte <= 8'h00;
      aw_idx <= 6'h00;
      w_lane <= 1'b0;
    end else begin
      reg_we <= 1'b0;
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_idx <= awaddr[7:2];
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        reg_wbyte <= wdata[7:0];
        w_lane <= wstrb[0];
      end
      if (!awready && !wready && !bvalid) begin
        bvalid <= 1'b1;
        bresp <= hit(aw_idx) ? twsc_pkg::RESP_OK : twsc_pkg::RESP_ERR;
        reg_we <= hit(aw_idx) && w_lane;
        reg_widx <= aw_idx;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= twsc_pkg::RESP_OK;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, hit(reg_ridx) ? reg_rbyte : 8'h00};
      rresp <= hit(reg_ridx) ? twsc_pkg::RESP_OK : twsc_pkg::RESP_ERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule : twsc_axil

// >>> verification/twsc_ctrl_sva.sv
`timescale 1ns/100ps
module twsc_ctrl_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [1:0] p1_o,
  input wire logic [1:0] p1_oe,
  input wire logic p1_pullup_en,
  input wire logic [1:0] p2_o,
  input wire logic [1:0] p2_oe,
  input wire logic p2_pullup_en,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken_s;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_taken_s;
    arvalid && arready;
  endsequence
  wr_answer_a:
    assert property (wr_taken_s |=> !awready ##1 bvalid) else $error("write not answered");
  rd_answer_a:
    assert property (rd_taken_s |=> rvalid && !arready) else $error("read not answered");
  resp_hold_a:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp moved");
  rdata_hold_a:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata moved");
  drive_low_a:
    assert property (p1_o == 2'h0 && p2_o == 2'h0) else $error("pin drives high");
  one_port_a:
    assert property (!(|p1_oe && |p2_oe)) else $error("both ports driven");
  pullup_off_one_a:
    assert property (|p1_oe |-> !p1_pullup_en) else $error("port 1 pull-up on");
  pullup_off_two_a:
    assert property (|p2_oe |-> !p2_pullup_en) else $error("port 2 pull-up on");
  irq_pulse_a:
    assert property (irq |=> !irq) else $error("irq wider than one cycle");
  reset_idle_a:
    assert property ($rose(aresetn) |-> !irq && !bvalid && p1_oe == 2'h0 && p2_oe == 2'h0)
    else $error("not idle after reset");
endmodule : twsc_ctrl_sva

bind twsc_ctrl twsc_ctrl_sva twsc_ctrl_sva_i (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .p1_o(p1_o), .p1_oe(p1_oe), .p1_pullup_en(p1_pullup_en),
  .p2_o(p2_o), .p2_oe(p2_oe), .p2_pullup_en(p2_pullup_en), .irq(irq));

// >>> verification/twsc_target_model.sv
`timescale 1ns/100ps
module twsc_target_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  input wire logic [15:0] stretch_ns,
  output logic sda_pull,
  output logic scl_pull,
  output logic [7:0] rx_byte,
  output logic stop_seen
);
  int bits;
  initial begin
    bits = 0;
    sda_pull = 1'b0;
    scl_pull = 1'b0;
    rx_byte = 8'h00;
    stop_seen = 1'b0;
  end
  // Start fall of the clock is counted too, hence minus one
  always @(negedge sda) begin
    if (scl) begin
      bits = -1;
      stop_seen = 1'b0;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      stop_seen = 1'b1;
    end
  end
  always @(posedge scl) begin
    if (bits < 8) begin
      rx_byte = {rx_byte[6:0], sda};
    end
  end
  always @(negedge scl) begin
    bits++;
    if (bits == 8) begin
      sda_pull = ack_en;
    end else if (bits == 9) begin
      sda_pull = 1'b0;
      bits = 0;
      // Slow target: controller must wait for the clock to rise
      if (stretch_ns > 16'h0000) begin
        scl_pull = 1'b1;
        #(stretch_ns) scl_pull = 1'b0;
      end
    end
  end
endmodule : twsc_target_model

// >>> verification/test_twsc_ctrl.sv
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module test_twsc_ctrl;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, irq, p1_pullup_en, p2_pullup_en, bm_scl, bm_sda, m_sda, m_scl;
  logic ack_en, stop_seen, scl, sda;
  logic [7:0] awaddr, araddr, rx_byte, b, d;
  logic [31:0] wdata, rdata, seed;
  logic [15:0] stretch_ns;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, p1_o, p1_oe, p2_o, p2_oe;
  int num_errors, num_checks, cyc;
  assign scl = !(p1_oe[0] || p2_oe[0] || bm_scl || m_scl);
  assign sda = !(p1_oe[1] || p2_oe[1] || bm_sda || m_sda);
  twsc_ctrl twsc_ctrl_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .p1_i({sda, scl}), .p1_o(p1_o), .p1_oe(p1_oe), .p1_pullup_en(p1_pullup_en),
    .p2_i({sda, scl}), .p2_o(p2_o), .p2_oe(p2_oe), .p2_pullup_en(p2_pullup_en), .irq(irq));
  twsc_target_model twsc_target_model_i (.scl(scl), .sda(sda), .ack_en(ack_en),
    .stretch_ns(stretch_ns), .sda_pull(m_sda), .scl_pull(m_scl), .rx_byte(rx_byte),
    .stop_seen(stop_seen));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = !aclk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      test_done();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [1:0] pulls(input logic pos, input logic wid);
    return (pos || wid) ? 2'b01 : 2'b10;
  endfunction : pulls
  task automatic axi_wr(input logic [5:0] idx, input logic [7:0] v, input logic [3:0] s,
    input logic [1:0] er);
    logic aw, w;
    @(posedge aclk);
    aw = 1'b0;
    w = 1'b0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, v};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready && !aw) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw && w));
    while (!bvalid) @(posedge aclk);
    `CHK(bresp, er)
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [5:0] idx, output logic [7:0] v, input logic [1:0] er);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    v = rdata[7:0];
    `CHK(rresp, er)
    rready <= 1'b0;
  endtask : axi_rd
  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!irq && n < 8000);
    `CHK(irq, 1'b1)
  endtask : wait_irq
  // External controller on the wire, 160 ns clock, phase offset from aclk
  task automatic link_byte(input logic [7:0] v);
    @(posedge aclk);
    #3 bm_sda = 1'b1;
    #80 bm_scl = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #40 bm_sda = !v[i];
      #40 bm_scl = 1'b0;
      #80 bm_scl = 1'b1;
    end
    #40 bm_sda = 1'b0;
  endtask : link_byte
  initial begin
    seed = 32'd97;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, bm_scl, bm_sda} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    ack_en = 1'b1;
    stretch_ns = 16'd3000;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(twsc_pkg::IDX_CTL, d, twsc_pkg::RESP_OK);
    `CHK(d, 8'h00)
    axi_rd(twsc_pkg::IDX_ROUTE, d, twsc_pkg::RESP_OK);
    `CHK(d, 8'h00)
    axi_rd(6'h30, d, twsc_pkg::RESP_ERR);
    `CHK(d, 8'h00)
    axi_wr(6'h30, 8'hff, 4'hf, twsc_pkg::RESP_ERR);
    axi_wr(twsc_pkg::IDX_ROUTE, 8'hff, 4'hf, twsc_pkg::RESP_OK);
    axi_wr(twsc_pkg::IDX_ROUTE, 8'h00, 4'h0, twsc_pkg::RESP_OK);
    axi_rd(twsc_pkg::IDX_ROUTE, d, twsc_pkg::RESP_OK);
    `CHK(d, 8'h82)
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      axi_wr(twsc_pkg::IDX_ROUTE, {i[1], 5'h00, i[0], 1'b0}, 4'hf, twsc_pkg::RESP_OK);
      axi_wr(twsc_pkg::IDX_CTL, 8'h01, 4'hf, twsc_pkg::RESP_OK);
      repeat (3) @(posedge aclk);
      `CHK({p2_pullup_en, p1_pullup_en}, pulls(i[1], i[0]))
      axi_wr(twsc_pkg::IDX_CTL, 8'h00, 4'hf, twsc_pkg::RESP_OK);
    end
    repeat (3) @(posedge aclk);
    `CHK({p2_pullup_en, p1_pullup_en}, 2'b11)
    $display("routing test done");
    b = 8'(rnd()) & 8'hfe;
    axi_wr(twsc_pkg::IDX_DATA, b, 4'hf, twsc_pkg::RESP_OK);
    axi_wr(twsc_pkg::IDX_CTL, 8'h81, 4'hf, twsc_pkg::RESP_OK);
    wait_irq();
    `CHK(rx_byte, b)
    axi_rd(twsc_pkg::IDX_CTL, d, twsc_pkg::RESP_OK);
    `CHK(d & 8'hd1, 8'h91)
    repeat (200) @(posedge aclk);
    `CHK(scl, 1'b0)
    $display("controller first byte done");
    ack_en = 1'b0;
    b = 8'(rnd());
    axi_wr(twsc_pkg::IDX_DATA, b, 4'hf, twsc_pkg::RESP_OK);
    axi_wr(twsc_pkg::IDX_CTL, 8'he1, 4'hf, twsc_pkg::RESP_OK);
    axi_rd(twsc_pkg::IDX_CTL, d, twsc_pkg::RESP_OK);
    `CHK(d[6], 1'b1)
    axi_wr(twsc_pkg::IDX_CTL, 8'h00, 4'hf, twsc_pkg::RESP_OK);
    wait_irq();
    `CHK(rx_byte, b)
    axi_rd(twsc_pkg::IDX_CTL, d, twsc_pkg::RESP_OK);
    `CHK(d & 8'hd1, 8'h81)
    $display("controller second byte done");
    axi_wr(twsc_pkg::IDX_CTL, 8'h01, 4'hf, twsc_pkg::RESP_OK);
    d = 8'h40;
    for (int n = 0; n < 400 && d[6] === 1'b1; n++) axi_rd(twsc_pkg::IDX_CTL, d, 2'h0);
    `CHK({stop_seen, scl, sda}, 3'b111)
    $display("stop test done");
    stretch_ns = 16'h0000;
    b = 8'(rnd());
    fork
      link_byte(b);
      wait_irq();
    join
    axi_rd(twsc_pkg::IDX_DATA, d, twsc_pkg::RESP_OK);
    `CHK(d, b)
    axi_rd(twsc_pkg::IDX_CTL, d, twsc_pkg::RESP_OK);
    `CHK(d & 8'hc9, 8'h09)
    #3 bm_scl = 1'b0;
    repeat (20) @(posedge aclk);
    `CHK(scl, 1'b0)
    axi_wr(twsc_pkg::IDX_CTL, 8'h51, 4'hf, twsc_pkg::RESP_OK);
    for (int n = 0; n < 400 && !scl; n++) @(posedge aclk);
    #40;
    `CHK(sda, 1'b0)
    fork
      begin
        #40 bm_scl = 1'b1;
        #80 bm_sda = 1'b1;
        #80 bm_scl = 1'b0;
        #80 bm_sda = 1'b0;
      end
      wait_irq();
    join
    axi_rd(twsc_pkg::IDX_CTL, d, twsc_pkg::RESP_OK);
    `CHK(d[1], 1'b1)
    $display("target test done");
    // Bench holds data low, so the final one bit loses arbitration
    axi_wr(twsc_pkg::IDX_DATA, 8'h01, 4'hf, twsc_pkg::RESP_OK);
    axi_wr(twsc_pkg::IDX_CTL, 8'h81, 4'hf, twsc_pkg::RESP_OK);
    fork
      begin
        wait (!sda);
        #3 bm_sda = 1'b1;
        repeat (8) @(posedge scl);
        #3000 bm_scl = 1'b1;
      end
      wait_irq();
    join
    axi_rd(twsc_pkg::IDX_CTL, d, twsc_pkg::RESP_OK);
    `CHK(d & 8'hcd, 8'h0d)
    $display("arbitration test done");
    test_done();
  end
endmodule : test_twsc_ctrl
